// File: logic/epd_pkg.sv
package epd_pkg;

  // timing
  localparam int SYS_HZ = 10_000_000;
  localparam int MS_TIME = 1;
  localparam int MS_CYCLES = SYS_HZ / 1000 * MS_TIME;
  localparam int SOFTSTART_STEP_MS = 10;
  localparam int FRAME_MS = 20;
  localparam int REFRESH_FRAMES = 4;
  localparam int SCL_HALF = 8;

  // frame memory: 176 x 296 pixels, one bit each, eight pixels a byte
  localparam int FRAME_BYTES = 176 * 296 / 8;

  // command codes
  localparam logic [7:0] CMD_POF = 8'h02;
  localparam logic [7:0] CMD_PFS = 8'h03;
  localparam logic [7:0] CMD_PON = 8'h04;
  localparam logic [7:0] CMD_MEASURE_ENABLE_CMD = 8'h05;
  localparam logic [7:0] CMD_BOOSTER_SOFTSTART_CMD = 8'h06;
  localparam logic [7:0] CMD_DEEP_SLEEP_CMD = 8'h07;
  localparam logic [7:0] CMD_IMAGE_LOAD_FIRST_CMD = 8'h10;
  localparam logic [7:0] CMD_DSP = 8'h11;
  localparam logic [7:0] CMD_DRF = 8'h12;
  localparam logic [7:0] DEEP_SLEEP_CMD_CHECK = 8'ha5;

  // parameter fields and reset values
  localparam logic [7:0] PFS_RESET = 8'h00;
  localparam logic [7:0] PFS_MASK = 8'h30;
  localparam int SOD_LSB = 4;
  localparam logic [7:0] BOOSTER_SOFTSTART_CMD_RESET = 8'h17;
  localparam logic [7:0] BTC_MASK = 8'h3f;
  localparam int BT_PERIOD_LSB = 6;
  localparam int BT_STR_LSB = 3;
  localparam int BT_OFF_LSB = 0;
  localparam int FLAG_BIT = 7;

  // frame plane select, follows the load mode
  localparam logic [1:0] MODE_BW = 2'h0;
  localparam logic [1:0] MODE_BWR = 2'h1;
  localparam logic [1:0] MODE_PROG = 2'h2;

  // host controller register map
  localparam logic [2:0] HR_TX = 3'h0;
  localparam logic [2:0] HR_STATUS = 3'h1;
  localparam logic [2:0] HR_RX = 3'h2;
  localparam logic [2:0] HR_IRQ_STAT = 3'h3;
  localparam logic [2:0] HR_IRQ_MASK = 3'h4;
  localparam int TX_DC_BIT = 8;
  localparam int TX_RD_BIT = 9;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READY = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

endpackage : epd_pkg

// File: logic/epd_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface epd_link_if;
  logic csb;
  logic scl;
  logic dc;
  logic host_sda;
  logic host_sda_oe;
  logic dev_sda;
  logic dev_sda_oe;
  logic busy_n;
  logic sda;

  // shared data wire with a pull-up
  assign sda = host_sda_oe ? host_sda : (dev_sda_oe ? dev_sda : 1'b1);

  modport host (output csb, scl, dc, host_sda, host_sda_oe, input sda, busy_n);
  modport dev (input csb, scl, dc, sda, output dev_sda, dev_sda_oe, busy_n);
endinterface : epd_link_if

`default_nettype wire

// File: logic/epd_link_rx.sv
`timescale 1ns/1ps
`default_nettype none

module epd_link_rx (
  // system
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // link pins
  input wire logic csb_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic dc_i,
  // decoded events
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic dc_o,
  output logic csb_fall_o,
  output logic csb_rise_o,
  output logic scl_fall_o
);
  // pin order in the sync vectors: csb, scl, sda, dc
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic csb_q;
    logic scl_q;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic valid;
    logic [7:0] data;
    logic csb_fall;
    logic csb_rise;
    logic scl_fall;
  } rx_s;

  rx_s r;
  rx_s n;

  always_comb begin
    n = r;
    n.s1 = {csb_i, scl_i, sda_i, dc_i};
    n.s2 = r.s1;
    n.csb_q = r.s2[3];
    n.scl_q = r.s2[2];
    n.valid = 1'b0;
    n.csb_fall = r.csb_q & ~r.s2[3];
    n.csb_rise = ~r.csb_q & r.s2[3];
    n.scl_fall = r.scl_q & ~r.s2[2] & ~r.s2[3];
    if (r.s2[3]) begin
      n.cnt = 3'h0;
    end else if (r.s2[2] && !r.scl_q) begin
      n.shift = {r.shift[6:0], r.s2[1]};
      n.cnt = r.cnt + 3'h1;
      if (r.cnt == 3'h7) begin
        n.valid = 1'b1;
        n.data = {r.shift[6:0], r.s2[1]};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{s1: 4'hf, s2: 4'hf, csb_q: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign byte_valid_o = r.valid;
  assign byte_o = r.data;
  assign dc_o = r.s2[0];
  assign csb_fall_o = r.csb_fall;
  assign csb_rise_o = r.csb_rise;
  assign scl_fall_o = r.scl_fall;
endmodule : epd_link_rx

`default_nettype wire

// File: logic/epd_device.sv
// Function
// - power-off timing bits 5-4 give 1-4 frames
// - power-on drops busy until sequence done
// - gated commands only while busy high
// - measure command enables sensing while off
// - phase A/B bits 7-6 set 10-40 ms
// - phase C bits 2-0 set minimum off
// - phase C bits 5-3 set drive strength
// - deep sleep only with check byte 0xA5
// - deep sleep left only by hardware reset
// - image bytes written to frame memory in order
// - image bytes routed to plane by mode
// - host ends image with data-stop command
// - data-stop read byte bit 7 is completion
// - completion flag set starts busy refresh
// - refresh command holds busy during refresh
// - don't-care parameter bits are ignored
// - power-off drops busy, keeps settings and memory
`timescale 1ns/1ps
`default_nettype none

module epd_device
  import epd_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES,
  parameter int unsigned FRAME_BYTES_P = FRAME_BYTES
) (
  // system
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // serial link
  epd_link_if.dev link,
  // panel configuration
  input wire logic [1:0] mode_i,
  // frame memory write port
  output logic fm_we_o,
  output logic [12:0] fm_addr_o,
  output logic [7:0] fm_data_o,
  output logic [1:0] fm_plane_o,
  // power and panel state
  output logic powered_o,
  output logic measure_en_o,
  output logic deep_sleep_o,
  output logic refreshing_o,
  // settings
  output logic [1:0] source_off_delay_o,
  output logic [7:0] booster_phase_a_o,
  output logic [7:0] booster_phase_b_o,
  output logic [7:0] booster_phase_c_o,
  output logic [3:0] boost_min_off_o,
  output logic [3:0] boost_strength_c_o
);
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001,
    SQ_PON = 4'b0010,
    SQ_POF = 4'b0100,
    SQ_REF = 4'b1000
  } seq_e;

  typedef struct packed {
    seq_e seq;
    logic [13:0] ms_div;
    logic [9:0] seq_ms;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [7:0] pot;
    logic [7:0] bt_a;
    logic [7:0] bt_b;
    logic [7:0] bt_c;
    logic [3:0] min_off;
    logic [3:0] strength_c;
    logic busy_n;
    logic powered;
    logic measure_en;
    logic deep_sleep;
    logic refreshing;
    logic [12:0] wr_addr;
    logic data_flag;
    logic rd_pending;
    logic [7:0] rd_shift;
    logic sda_oe;
    logic fm_we;
    logic [12:0] fm_addr;
    logic [7:0] fm_data;
    logic [1:0] fm_plane;
  } dev_s;

  localparam logic [3:0] MIN_OFF_RESET = {1'b0, BOOSTER_SOFTSTART_CMD_RESET[BT_OFF_LSB +: 3]} + 4'h1;
  localparam logic [3:0] STRENGTH_RESET = {1'b0, BOOSTER_SOFTSTART_CMD_RESET[BT_STR_LSB +: 3]} + 4'h1;
  localparam logic [9:0] REFRESH_MS = 10'(REFRESH_FRAMES * FRAME_MS);

  localparam dev_s DEV_RESET = '{
    seq: SQ_IDLE,
    pot: PFS_RESET,
    bt_a: BOOSTER_SOFTSTART_CMD_RESET,
    bt_b: BOOSTER_SOFTSTART_CMD_RESET,
    bt_c: BOOSTER_SOFTSTART_CMD_RESET,
    min_off: MIN_OFF_RESET,
    strength_c: STRENGTH_RESET,
    busy_n: 1'b1,
    default: '0
  };

  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_dc;
  logic rx_csb_fall;
  logic rx_csb_rise;
  logic rx_scl_fall;

  dev_s r;
  dev_s n;

  epd_link_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .csb_i(link.csb),
    .scl_i(link.scl),
    .sda_i(link.sda),
    .dc_i(link.dc),
    .byte_valid_o(rx_valid),
    .byte_o(rx_byte),
    .dc_o(rx_dc),
    .csb_fall_o(rx_csb_fall),
    .csb_rise_o(rx_csb_rise),
    .scl_fall_o(rx_scl_fall)
  );

  always_comb begin
    logic tick;
    logic ok;
    logic ref_go;
    tick = 1'b0;
    ok = r.busy_n;
    ref_go = 1'b0;
    n = r;
    n.fm_we = 1'b0;

    // millisecond pacing of the busy sequences
    if (r.seq != SQ_IDLE) begin
      if (r.ms_div == 14'(MS_CYCLES_P - 1)) begin
        n.ms_div = 14'h0;
        tick = 1'b1;
      end else begin
        n.ms_div = r.ms_div + 14'h1;
      end
      if (tick) begin
        if (r.seq_ms <= 10'h1) begin
          n.seq = SQ_IDLE;
          n.busy_n = 1'b1;
          n.refreshing = 1'b0;
        end else begin
          n.seq_ms = r.seq_ms - 10'h1;
        end
      end
    end

    // completion flag read-back, shifted out on falling clock edges
    if (rx_csb_fall && rx_dc && r.rd_pending) begin
      n.sda_oe = 1'b1;
      n.rd_shift = 8'h0;
      n.rd_shift[FLAG_BIT] = r.data_flag;
      n.rd_pending = 1'b0;
    end else if (rx_scl_fall && r.sda_oe) begin
      n.rd_shift = {r.rd_shift[6:0], 1'b0};
    end
    if (rx_csb_rise) begin
      n.sda_oe = 1'b0;
    end

    // after deep sleep every byte is dropped until reset
    if (rx_valid && !r.deep_sleep) begin
      if (!rx_dc) begin
        n.cmd = rx_byte;
        n.pidx = 2'h0;
        n.rd_pending = 1'b0;
        case (rx_byte)
          CMD_PON: begin
            if (ok) begin
              n.busy_n = 1'b0;
              n.seq = SQ_PON;
              n.ms_div = 14'h0;
              n.seq_ms = (10'(r.bt_a[BT_PERIOD_LSB +: 2]) + 10'(r.bt_b[BT_PERIOD_LSB +: 2])
                          + 10'h2) * 10'(SOFTSTART_STEP_MS);
              n.powered = 1'b1;
            end
          end
          CMD_POF: begin
            if (ok) begin
              n.busy_n = 1'b0;
              n.seq = SQ_POF;
              n.ms_div = 14'h0;
              n.seq_ms = (10'(r.pot[SOD_LSB +: 2]) + 10'h1) * 10'(FRAME_MS);
              n.powered = 1'b0;
              n.measure_en = 1'b0;
            end
          end
          CMD_MEASURE_ENABLE_CMD: begin
            if (ok) begin
              n.measure_en = 1'b1;
            end
          end
          CMD_IMAGE_LOAD_FIRST_CMD: begin
            n.wr_addr = 13'h0;
            n.data_flag = 1'b0;
          end
          CMD_DSP: begin
            if (ok) begin
              n.rd_pending = 1'b1;
              ref_go = r.data_flag;
            end
          end
          CMD_DRF: begin
            ref_go = ok;
          end
          default: begin
          end
        endcase
      end else begin
        if (r.pidx != 2'h3) begin
          n.pidx = r.pidx + 2'h1;
        end
        case (r.cmd)
          CMD_PFS: begin
            if (r.pidx == 2'h0) begin
              n.pot = rx_byte & PFS_MASK;
            end
          end
          CMD_BOOSTER_SOFTSTART_CMD: begin
            if (r.pidx == 2'h0) begin
              n.bt_a = rx_byte;
            end else if (r.pidx == 2'h1) begin
              n.bt_b = rx_byte;
            end else if (r.pidx == 2'h2) begin
              n.bt_c = rx_byte & BTC_MASK;
              n.min_off = {1'b0, rx_byte[BT_OFF_LSB +: 3]} + 4'h1;
              n.strength_c = {1'b0, rx_byte[BT_STR_LSB +: 3]} + 4'h1;
            end
          end
          CMD_DEEP_SLEEP_CMD: begin
            if (r.pidx == 2'h0 && rx_byte == DEEP_SLEEP_CMD_CHECK && ok) begin
              n.deep_sleep = 1'b1;
              n.powered = 1'b0;
              n.measure_en = 1'b0;
            end
          end
          CMD_IMAGE_LOAD_FIRST_CMD: begin
            if (!r.data_flag) begin
              n.fm_we = 1'b1;
              n.fm_addr = r.wr_addr;
              n.fm_data = rx_byte;
              n.fm_plane = mode_i;
              if (r.wr_addr == 13'(FRAME_BYTES_P - 1)) begin
                n.data_flag = 1'b1;
              end else begin
                n.wr_addr = r.wr_addr + 13'h1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // panel drive begins only on data-stop or refresh
    if (ref_go) begin
      n.busy_n = 1'b0;
      n.seq = SQ_REF;
      n.ms_div = 14'h0;
      n.seq_ms = REFRESH_MS;
      n.refreshing = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= DEV_RESET;
    end else begin
      r <= n;
    end
  end

  assign link.dev_sda = r.rd_shift[FLAG_BIT];
  assign link.dev_sda_oe = r.sda_oe;
  assign link.busy_n = r.busy_n;
  assign fm_we_o = r.fm_we;
  assign fm_addr_o = r.fm_addr;
  assign fm_data_o = r.fm_data;
  assign fm_plane_o = r.fm_plane;
  assign powered_o = r.powered;
  assign measure_en_o = r.measure_en;
  assign deep_sleep_o = r.deep_sleep;
  assign refreshing_o = r.refreshing;
  assign source_off_delay_o = r.pot[SOD_LSB +: 2];
  assign booster_phase_a_o = r.bt_a;
  assign booster_phase_b_o = r.bt_b;
  assign booster_phase_c_o = r.bt_c;
  assign boost_min_off_o = r.min_off;
  assign boost_strength_c_o = r.strength_c;
endmodule : epd_device

`default_nettype wire

// File: logic/epd_host.sv
`timescale 1ns/1ps
`default_nettype none

module epd_host
  import epd_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // serial link
  epd_link_if.host link,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o,
  // interrupt
  output logic irq_o
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_SHIFT = 3'b100
  } host_e;

  typedef struct packed {
    host_e st;
    logic [3:0] div;
    logic scl;
    logic csb;
    logic sda;
    logic sda_oe;
    logic dc;
    logic rd;
    logic [2:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [1:0] bsy;
    logic [1:0] sdq;
    logic busy_prev;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic [15:0] rdata;
  } host_s;

  host_s r;
  host_s n;

  always_comb begin
    logic [1:0] set;
    set = 2'h0;
    n = r;
    n.rdata = 16'h0;
    n.bsy = {r.bsy[0], link.busy_n};
    n.sdq = {r.sdq[0], link.sda};
    n.busy_prev = r.bsy[1];
    set[IRQ_READY] = r.bsy[1] & ~r.busy_prev;

    unique case (r.st)
      HS_IDLE: begin
        if (we_i && addr_i == HR_TX) begin
          n.tx = wdata_i[7:0];
          n.dc = wdata_i[TX_DC_BIT];
          n.rd = wdata_i[TX_RD_BIT];
          n.st = HS_WAIT;
        end
      end
      HS_WAIT: begin
        // a command byte waits for the device to be ready
        if (r.dc || r.bsy[1]) begin
          n.csb = 1'b0;
          n.scl = 1'b0;
          n.sda_oe = ~r.rd;
          n.sda = r.tx[7];
          n.div = 4'h0;
          n.bitn = 3'h0;
          n.st = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (r.div == 4'(SCL_HALF - 1)) begin
          n.div = 4'h0;
          if (!r.scl) begin
            n.scl = 1'b1;
            n.rx = {r.rx[6:0], r.sdq[1]};
          end else begin
            n.scl = 1'b0;
            if (r.bitn == 3'h7) begin
              n.csb = 1'b1;
              n.sda_oe = 1'b0;
              n.st = HS_IDLE;
              set[IRQ_DONE] = 1'b1;
            end else begin
              n.bitn = r.bitn + 3'h1;
              n.tx = {r.tx[6:0], 1'b0};
              n.sda = r.tx[6];
            end
          end
        end else begin
          n.div = r.div + 4'h1;
        end
      end
    endcase

    // sticky events, write one to clear, a new event wins
    if (we_i && addr_i == HR_IRQ_STAT) begin
      n.stat = (r.stat & ~wdata_i[1:0]) | set;
    end else begin
      n.stat = r.stat | set;
    end
    if (we_i && addr_i == HR_IRQ_MASK) begin
      n.mask = wdata_i[1:0];
    end
    n.irq = |(n.stat & n.mask);

    if (re_i) begin
      unique case (addr_i)
        HR_STATUS: n.rdata = {14'h0, r.bsy[1], r.st != HS_IDLE};
        HR_RX: n.rdata = {8'h0, r.rx};
        HR_IRQ_STAT: n.rdata = {14'h0, r.stat};
        HR_IRQ_MASK: n.rdata = {14'h0, r.mask};
        default: n.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{st: HS_IDLE, csb: 1'b1, mask: IRQ_MASK_RESET, default: '0};
    end else begin
      r <= n;
    end
  end

  assign link.csb = r.csb;
  assign link.scl = r.scl;
  assign link.dc = r.dc;
  assign link.host_sda = r.sda;
  assign link.host_sda_oe = r.sda_oe;
  assign rdata_o = r.rdata;
  assign irq_o = r.irq;
endmodule : epd_host

`default_nettype wire

// File: verif/epd_link_sva.sv
`timescale 1ns/1ps
`default_nettype none

module epd_link_sva
  import epd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic csb,
  input wire logic scl,
  input wire logic dc,
  input wire logic host_sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda,
  input wire logic dev_sda_oe,
  input wire logic busy_n,
  input wire logic sda
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic scl_reg;
  logic [3:0] rise_reg;
  logic [7:0] shift_reg;
  logic rise;
  logic last;
  logic [7:0] cmd;

  // eighth rising clock of a command byte, with the byte as it completes
  assign rise = scl && !scl_reg && !csb;
  assign last = rise && rise_reg == 4'h7 && !dc && busy_n;
  assign cmd = {shift_reg[6:0], sda};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_reg <= 1'b0;
      rise_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      rise_reg <= csb ? 4'h0 : rise_reg + {3'h0, rise};
      if (rise) begin
        shift_reg <= cmd;
      end
    end
  end

  scl_idle_a: assert property (csb |-> !scl)
    else $error("clock moved outside a frame");
  dc_hold_a: assert property (!csb && !$past(csb) |-> $stable(dc))
    else $error("select changed inside a frame");
  cmd_gate_a: assert property ($fell(csb) && !dc |-> busy_n)
    else $error("command started while busy");
  bit_hold_a: assert property (host_sda_oe && scl && $past(scl) |-> $stable(host_sda))
    else $error("data moved while clock high");
  frame_bits_a: assert property ($rose(csb) |-> rise_reg == 4'h8)
    else $error("frame without eight clock pulses");
  read_drive_a: assert property (dev_sda_oe |-> !host_sda_oe && dc && sda == dev_sda)
    else $error("device drove data outside a read");
  pon_busy_a: assert property (last && cmd == CMD_PON |-> ##[2:20] !busy_n [*8])
    else $error("power-on left busy high");
  drf_busy_a: assert property (last && cmd == CMD_DRF |-> ##[2:20] !busy_n [*8])
    else $error("refresh left busy high");
  pof_busy_a: assert property (last && cmd == CMD_POF |-> ##[2:20] !busy_n [*8])
    else $error("power-off left busy high");
endmodule : epd_link_sva

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import epd_pkg::*;
  localparam int MSC = 10;
  logic clk, rst_n, we, re, irq, fm_we, powered, measure_en, deep_sleep, refreshing;
  logic [1:0] mode, fm_plane, sod;
  logic [2:0] addr;
  logic [15:0] wdata, rdata;
  logic [12:0] fm_addr;
  logic [7:0] fm_data, pha, phb, phc;
  logic [3:0] min_off, strength;
  logic [22:0] fq[$];
  int err_total = 0;
  int tests_run = 0;
  int low_cnt = 0;

  epd_link_if link_if ();
  epd_device #(.MS_CYCLES_P(MSC), .FRAME_BYTES_P(4)) u_epd_device (
    .sys_clk_i(clk), .rst_n_i(rst_n), .link(link_if), .mode_i(mode),
    .fm_we_o(fm_we), .fm_addr_o(fm_addr), .fm_data_o(fm_data), .fm_plane_o(fm_plane),
    .powered_o(powered), .measure_en_o(measure_en), .deep_sleep_o(deep_sleep),
    .refreshing_o(refreshing), .source_off_delay_o(sod), .booster_phase_a_o(pha),
    .booster_phase_b_o(phb), .booster_phase_c_o(phc), .boost_min_off_o(min_off),
    .boost_strength_c_o(strength));
  epd_host u_epd_host (
    .sys_clk_i(clk), .rst_n_i(rst_n), .link(link_if), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .irq_o(irq));
  epd_link_sva u_epd_link_sva (
    .sys_clk_i(clk), .rst_n_i(rst_n), .csb(link_if.csb), .scl(link_if.scl),
    .dc(link_if.dc), .host_sda(link_if.host_sda), .host_sda_oe(link_if.host_sda_oe),
    .dev_sda(link_if.dev_sda), .dev_sda_oe(link_if.dev_sda_oe),
    .busy_n(link_if.busy_n), .sda(link_if.sda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // busy length and frame writes are gathered beside the stimulus
  always @(posedge clk) begin
    if (link_if.busy_n === 1'b0) low_cnt++;
    if (fm_we === 1'b1) fq.push_back({fm_plane, fm_addr, fm_data});
  end

  function automatic int len_of(input int units, input int ms);
    return units * ms * MSC;
  endfunction : len_of

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_len(input int exp);
    int n;
    n = 0;
    while (low_cnt == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (link_if.busy_n !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (link_if.busy_n !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t busy never released", $time);
    end
    tests_run++;
    if (low_cnt < exp - 4 || low_cnt > exp + 4) begin
      err_total++;
      $display("[ERR] %0t busy low %0d cycles expected %0d", $time, low_cnt, exp);
    end
  endtask : chk_len

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic send(input logic [7:0] b, input logic dc, input logic rdf);
    int n;
    n = 0;
    wr(HR_TX, {6'h00, rdf, dc, b});
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t byte never completed", $time);
    end
    wr(HR_IRQ_STAT, 16'h0001);
  endtask : send

  task automatic do_cmd(input logic [7:0] b, input int exp);
    low_cnt = 0;
    send(b, 1'b0, 1'b0);
    chk_len(exp);
  endtask : do_cmd

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [15:0] v;
    logic [7:0] a, b, c;
    logic [7:0] px[4];
    int n, seed, cnt;
    seed = $urandom(32'hd9392a82);
    rst_n = 1'b0;
    mode = 2'h0;
    addr = 3'h0;
    wdata = 16'h0000;
    we = 1'b0;
    re = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(sod), 32'h0);
    chk(32'(pha), 32'(BOOSTER_SOFTSTART_CMD_RESET));
    chk(32'(min_off), 32'h8);
    chk(32'(strength), 32'h3);
    rd(3'h7, v);
    chk(32'(v), 32'h0);
    rd(HR_STATUS, v);
    chk(32'(v), 32'h2);
    tdone("reset");
    // a masked event stays off the interrupt line until unmasked
    wr(HR_TX, {8'h00, CMD_PFS});
    n = 0;
    do begin
      rd(HR_IRQ_STAT, v);
      n++;
    end while (v[IRQ_DONE] !== 1'b1 && n < 200);
    chk(32'(irq), 32'h0);
    wr(HR_IRQ_MASK, 16'h0003);
    rd(HR_IRQ_MASK, v);
    chk(32'(irq), 32'h1);
    wr(HR_IRQ_STAT, 16'h0003);
    wr(HR_IRQ_MASK, 16'h0001);
    chk(32'(irq), 32'h0);
    tdone("interrupt");
    for (int k = 0; k < 4; k++) begin
      send(CMD_PFS, 1'b0, 1'b0);
      send({2'($urandom), 2'(k), 4'($urandom)}, 1'b1, 1'b0);
      chk(32'(sod), 32'(k));
    end
    for (int r = 0; r < 3; r++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      send(CMD_BOOSTER_SOFTSTART_CMD, 1'b0, 1'b0);
      send(a, 1'b1, 1'b0);
      send(b, 1'b1, 1'b0);
      send(c, 1'b1, 1'b0);
      chk(32'(pha), 32'(a));
      chk(32'(phb), 32'(b));
      chk(32'(phc), 32'({2'h0, c[5:0]}));
      chk(32'(min_off), 32'(c[2:0]) + 1);
      chk(32'(strength), 32'(c[5:3]) + 1);
    end
    tdone("settings");
    do_cmd(CMD_PON, len_of(a[7:6] + b[7:6] + 2, SOFTSTART_STEP_MS));
    chk(32'(powered), 32'h1);
    send(CMD_MEASURE_ENABLE_CMD, 1'b0, 1'b0);
    chk(32'(measure_en), 32'h1);
    tdone("power on");
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      fq.delete();
      cnt = (m == 0) ? 3 : 4;
      send(CMD_IMAGE_LOAD_FIRST_CMD, 1'b0, 1'b0);
      for (int i = 0; i < cnt; i++) begin
        px[i] = 8'($urandom);
        send(px[i], 1'b1, 1'b0);
      end
      chk(32'(fq.size()), 32'(cnt));
      foreach (fq[i]) chk(32'(fq[i]), 32'({2'(m), 13'(i), px[i]}));
      low_cnt = 0;
      send(CMD_DSP, 1'b0, 1'b0);
      send(8'h00, 1'b1, 1'b1);
      rd(HR_RX, v);
      chk(32'(v[FLAG_BIT]), 32'(m != 0));
      chk(32'(refreshing), 32'(m != 0));
      chk_len((m != 0) ? len_of(REFRESH_FRAMES, FRAME_MS) : 0);
    end
    tdone("frame load");
    do_cmd(CMD_DRF, len_of(REFRESH_FRAMES, FRAME_MS));
    do_cmd(CMD_POF, len_of(4, FRAME_MS));
    chk(32'(powered), 32'h0);
    chk(32'(pha), 32'(a));
    tdone("refresh and power off");
    send(CMD_DEEP_SLEEP_CMD, 1'b0, 1'b0);
    send(8'h5a, 1'b1, 1'b0);
    chk(32'(deep_sleep), 32'h0);
    send(CMD_DEEP_SLEEP_CMD, 1'b0, 1'b0);
    send(DEEP_SLEEP_CMD_CHECK, 1'b1, 1'b0);
    chk(32'(deep_sleep), 32'h1);
    send(CMD_MEASURE_ENABLE_CMD, 1'b0, 1'b0);
    chk(32'(measure_en), 32'h0);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(deep_sleep), 32'h0);
    chk(32'(link_if.busy_n), 32'h1);
    tdone("deep sleep");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
